/* design/tcc_pkg.sv */
package tcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS = 8'hC8;
    localparam logic [7:0] IDX_CTRL = 8'hEA;
    localparam logic [7:0] IDX_EDGE = 8'hEB;
    localparam logic [7:0] IDX_SET = 8'hEE;
    localparam logic [7:0] IDX_CLRTG = 8'hEF;
    localparam logic [7:0] IDX_COUNT = 8'hF0;
    localparam logic [7:0] IDX_CMP0 = 8'hF1;
    localparam logic [7:0] IDX_CMP1 = 8'hF2;
    localparam logic [7:0] IDX_CMP2 = 8'hF3;
    localparam logic [7:0] IDX_CAP0 = 8'hF4;
    localparam logic [7:0] IDX_CAP1 = 8'hF5;
    localparam logic [7:0] IDX_CAP2 = 8'hF6;
    localparam logic [7:0] IDX_CAP3 = 8'hF7;
    localparam logic [7:0] IDX_IRQ_EN = 8'hF8;
    localparam logic [7:0] IDX_IRQ_PRI = 8'hF9;
    localparam logic [7:0] IDX_PORT = 8'hFA;

    ////////////////////////////////////////////////////////////////////////////
    // counter_control fields
    localparam int CTL_FULL_SEL = 7;
    localparam int CTL_LOW_SEL = 6;
    localparam int CTL_EXT_CLR = 5;
    localparam int CTL_LOW_FLAG = 4;
    localparam int CTL_PRE_HI = 3;
    localparam int CTL_PRE_LO = 2;
    localparam int CTL_SRC_HI = 1;
    localparam int CTL_SRC_LO = 0;

    // Clock source codes
    localparam logic [1:0] SRC_HALT = 2'h0;
    localparam logic [1:0] SRC_MACH = 2'h1;
    localparam logic [1:0] SRC_TEST = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;

    // Prescaler masks for divide by 1, 2, 4, 8
    localparam logic [2:0] PRE_MASK1 = 3'h0;
    localparam logic [2:0] PRE_MASK2 = 3'h1;
    localparam logic [2:0] PRE_MASK4 = 3'h3;
    localparam logic [2:0] PRE_MASK8 = 3'h7;

    // timer_event_flags fields
    localparam int FLG_OVF = 7;
    localparam int FLG_MATCH0 = 4;
    localparam int FLG_CAP0 = 0;

    // Input pin slots after the synchroniser
    localparam int PIN_CLK = 4;
    localparam int PIN_CLR = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_PRE = 3'h0;
    localparam logic [1:0] RST_TG = 2'h0;
    localparam logic [31:0] RST_BUS = 32'h00000000;

endpackage

/* design/tcc_sync.sv */
`timescale 1ns/1ps
module tcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, synchronous levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_meta = d_i;
        nxt_q = meta_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_o <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q_o <= nxt_q;
        end
    end

endmodule

/* design/tcc_timer2_capcmp.sv */
// Functional notes
// - Prescaler divides the selected source by 1, 2, 4 or 8 per control bits 3:2.
// - Source field halts, uses machine clock, or external pin; code 10 is test only.
// - Control bit 5 enables external clear; when clear the input is ignored.
// - Bit 7 enables full overflow request, bit 6 low-byte overflow; shared vector.
// - Control bit 4 is set on low-byte overflow; only software clears it.
// - Capture edge bits: 2n+1 falling, 2n rising, both or none per input.
// - Flag register: bit 7 overflow, bits 6:4 compare 2..0, bits 3:0 captures.
// - Interrupt requests gated by enable register, priority from priority register.
// - Match of compare 0 sets port bit n (0..5) when its set enable is high.
// - Set enable low leaves port bit n untouched by compare 0 match.
// - Set enable bits 7:6 show pending toggle direction of port bits 7:6.
// - Set enable bits 7:6 are read-only.
// - Toggle enable bits 7:6 invert port bits 7:6 on compare 2 match.
// - Match of compare 1 clears port bit n (0..5) when its clear enable is high.
// - Clear/toggle enable low leaves port bit unaffected by compare 1 or 2.
// - Enabled capture edge copies counter to capture register and sets its flag.
// - Simultaneous compare 0 and 1 matches clear enabled port bits 0..5.
// - Enabled external clear rising edge zeroes counter; chip reset too; no load.
// - Every flag stays set until software clears it.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module tcc_timer2_capcmp (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External pins
    input wire logic [3:0] capture_in_i,
    input wire logic ext_clock_i,
    input wire logic ext_clear_input_i,
    // Port and interrupt outputs
    output logic [7:0] match_output_port_o,
    output logic irq_o,
    output logic irq_prio_o
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        return a == want;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection
    logic [5:0] pin_s, pin_d_ff, nxt_pin_d, rise, fall;

    tcc_sync #(.W(6)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ext_clear_input_i, ext_clock_i, capture_in_i}),
        .q_o(pin_s)
    );

    always_comb begin
        nxt_pin_d = pin_s;
        rise = pin_s & ~pin_d_ff;
        fall = ~pin_s & pin_d_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_d_ff <= '0;
        end else begin
            pin_d_ff <= nxt_pin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake; writes land on the edge where the master sees ack
    logic ack_ff, nxt_ack, wr_lo, wr_hi;
    logic [31:0] nxt_dat, rdata;
    logic [7:0] idx;

    always_comb begin
        idx = wb_adr_i[9:2];
        wr_lo = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
        wr_hi = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[1];
        nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_dat = nxt_ack ? rdata : tcc_pkg::RST_BUS;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            wb_dat_o <= tcc_pkg::RST_BUS;
        end else begin
            ack_ff <= nxt_ack;
            wb_dat_o <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter
    logic [7:0] ctl_ff;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [2:0] pre_ff, nxt_pre, pre_mask;
    logic upd_ff, nxt_upd, src_tick, tick, ext_clr, ctl_wr, ovf_full, ovf_low;

    always_comb begin
        ctl_wr = wr_lo & hit(idx, tcc_pkg::IDX_CTRL);
        // Test code counts nothing: treated as halted
        case (ctl_ff[tcc_pkg::CTL_SRC_HI:tcc_pkg::CTL_SRC_LO])
            tcc_pkg::SRC_MACH: src_tick = 1'b1;
            tcc_pkg::SRC_PIN: src_tick = rise[tcc_pkg::PIN_CLK];
            default: src_tick = 1'b0;
        endcase
        case (ctl_ff[tcc_pkg::CTL_PRE_HI:tcc_pkg::CTL_PRE_LO])
            2'h0: pre_mask = tcc_pkg::PRE_MASK1;
            2'h1: pre_mask = tcc_pkg::PRE_MASK2;
            2'h2: pre_mask = tcc_pkg::PRE_MASK4;
            default: pre_mask = tcc_pkg::PRE_MASK8;
        endcase
        tick = src_tick & ((pre_ff & pre_mask) == pre_mask);
        ext_clr = ctl_ff[tcc_pkg::CTL_EXT_CLR] & rise[tcc_pkg::PIN_CLR];
        ovf_full = tick & (cnt_ff == 16'hFFFF);
        ovf_low = tick & (cnt_ff[7:0] == 8'hFF);
        if (ext_clr || (ctl_wr && (wb_dat_i[3:0] != ctl_ff[3:0]))) begin
            nxt_pre = tcc_pkg::RST_PRE;
        end else if (src_tick) begin
            nxt_pre = pre_ff + 3'h1;
        end else begin
            nxt_pre = pre_ff;
        end
        if (ext_clr) begin
            nxt_cnt = tcc_pkg::RST_WORD;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end else begin
            nxt_cnt = cnt_ff;
        end
        nxt_upd = ext_clr | tick;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= tcc_pkg::RST_WORD;
            pre_ff <= tcc_pkg::RST_PRE;
            upd_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pre_ff <= nxt_pre;
            upd_ff <= nxt_upd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Captures; each sees the count held before this edge
    logic [7:0] edge_ff;
    logic [3:0] cap_ev;
    logic [15:0] cap_ff [4];

    for (genvar i = 0; i < 4; i++) begin : g_cap
        logic [15:0] nxt_cap;
        always_comb begin
            cap_ev[i] = (rise[i] & edge_ff[2*i]) | (fall[i] & edge_ff[2*i+1]);
            nxt_cap = cap_ev[i] ? cnt_ff : cap_ff[i];
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cap_ff[i] <= tcc_pkg::RST_WORD;
            end else begin
                cap_ff[i] <= nxt_cap;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare, flags, port and interrupt state
    // A match only counts on the cycle the counter moves, so a slow
    // prescale does not repeat a toggle while the count sits still.
    logic [15:0] cmp_ff [3], nxt_cmp [3];
    logic [2:0] match;
    logic [7:0] nxt_ctl, nxt_edge, flags_ff, nxt_flags, clrtg_ff, nxt_clrtg;
    logic [7:0] irq_en_ff, nxt_irq_en, irq_pri_ff, nxt_irq_pri, nxt_port, req;
    logic [5:0] set_en_ff, nxt_set_en;
    logic [1:0] tg_ff, nxt_tg;
    logic nxt_irq, nxt_prio;

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            match[k] = upd_ff & (cnt_ff == cmp_ff[k]);
            nxt_cmp[k] = cmp_ff[k];
            if (wr_lo && hit(idx, tcc_pkg::IDX_CMP0 + 8'(k))) begin
                nxt_cmp[k][7:0] = wb_dat_i[7:0];
            end
            if (wr_hi && hit(idx, tcc_pkg::IDX_CMP0 + 8'(k))) begin
                nxt_cmp[k][15:8] = wb_dat_i[15:8];
            end
        end
        // Hardware set wins over a clearing write in the same cycle
        nxt_ctl = ctl_wr ? wb_dat_i[7:0] : ctl_ff;
        nxt_ctl[tcc_pkg::CTL_LOW_FLAG] = nxt_ctl[tcc_pkg::CTL_LOW_FLAG] | ovf_low;
        nxt_flags = (wr_lo && hit(idx, tcc_pkg::IDX_FLAGS)) ? wb_dat_i[7:0] : flags_ff;
        nxt_flags = nxt_flags | {ovf_full, match, cap_ev};
        nxt_edge = (wr_lo && hit(idx, tcc_pkg::IDX_EDGE)) ? wb_dat_i[7:0] : edge_ff;
        nxt_set_en = (wr_lo && hit(idx, tcc_pkg::IDX_SET)) ? wb_dat_i[5:0] : set_en_ff;
        nxt_clrtg = (wr_lo && hit(idx, tcc_pkg::IDX_CLRTG)) ? wb_dat_i[7:0] : clrtg_ff;
        nxt_irq_en = (wr_lo && hit(idx, tcc_pkg::IDX_IRQ_EN)) ? wb_dat_i[7:0] : irq_en_ff;
        nxt_irq_pri = (wr_lo && hit(idx, tcc_pkg::IDX_IRQ_PRI)) ? wb_dat_i[7:0] : irq_pri_ff;
        // Software port writes never disturb the toggle state
        nxt_port = (wr_lo && hit(idx, tcc_pkg::IDX_PORT)) ? wb_dat_i[7:0]
                                                          : match_output_port_o;
        nxt_tg = tg_ff;
        for (int n = 0; n < 6; n++) begin
            if (match[1] && clrtg_ff[n]) begin
                nxt_port[n] = 1'b0;
            end else if (match[0] && set_en_ff[n]) begin
                nxt_port[n] = 1'b1;
            end
        end
        for (int n = 0; n < 2; n++) begin
            if (match[2] && clrtg_ff[6+n]) begin
                nxt_port[6+n] = ~tg_ff[n];
                nxt_tg[n] = ~tg_ff[n];
            end
        end
        req = flags_ff;
        req[tcc_pkg::FLG_OVF] = (flags_ff[tcc_pkg::FLG_OVF] & ctl_ff[tcc_pkg::CTL_FULL_SEL])
            | (ctl_ff[tcc_pkg::CTL_LOW_FLAG] & ctl_ff[tcc_pkg::CTL_LOW_SEL]);
        nxt_irq = |(req & irq_en_ff);
        nxt_prio = |(req & irq_en_ff & irq_pri_ff);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < 3; k++) begin
                cmp_ff[k] <= tcc_pkg::RST_WORD;
            end
            ctl_ff <= tcc_pkg::RST_BYTE;
            flags_ff <= tcc_pkg::RST_BYTE;
            edge_ff <= tcc_pkg::RST_BYTE;
            set_en_ff <= '0;
            clrtg_ff <= tcc_pkg::RST_BYTE;
            tg_ff <= tcc_pkg::RST_TG;
            irq_en_ff <= tcc_pkg::RST_BYTE;
            irq_pri_ff <= tcc_pkg::RST_BYTE;
            match_output_port_o <= tcc_pkg::RST_BYTE;
            irq_o <= 1'b0;
            irq_prio_o <= 1'b0;
        end else begin
            cmp_ff <= nxt_cmp;
            ctl_ff <= nxt_ctl;
            flags_ff <= nxt_flags;
            edge_ff <= nxt_edge;
            set_en_ff <= nxt_set_en;
            clrtg_ff <= nxt_clrtg;
            tg_ff <= nxt_tg;
            irq_en_ff <= nxt_irq_en;
            irq_pri_ff <= nxt_irq_pri;
            match_output_port_o <= nxt_port;
            irq_o <= nxt_irq;
            irq_prio_o <= nxt_prio;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped indices read zero
    always_comb begin
        rdata = tcc_pkg::RST_BUS;
        case (idx)
            tcc_pkg::IDX_FLAGS: rdata[7:0] = flags_ff;
            tcc_pkg::IDX_CTRL: rdata[7:0] = ctl_ff;
            tcc_pkg::IDX_EDGE: rdata[7:0] = edge_ff;
            tcc_pkg::IDX_SET: rdata[7:0] = {tg_ff, set_en_ff};
            tcc_pkg::IDX_CLRTG: rdata[7:0] = clrtg_ff;
            tcc_pkg::IDX_COUNT: rdata[15:0] = cnt_ff;
            tcc_pkg::IDX_CMP0: rdata[15:0] = cmp_ff[0];
            tcc_pkg::IDX_CMP1: rdata[15:0] = cmp_ff[1];
            tcc_pkg::IDX_CMP2: rdata[15:0] = cmp_ff[2];
            tcc_pkg::IDX_CAP0: rdata[15:0] = cap_ff[0];
            tcc_pkg::IDX_CAP1: rdata[15:0] = cap_ff[1];
            tcc_pkg::IDX_CAP2: rdata[15:0] = cap_ff[2];
            tcc_pkg::IDX_CAP3: rdata[15:0] = cap_ff[3];
            tcc_pkg::IDX_IRQ_EN: rdata[7:0] = irq_en_ff;
            tcc_pkg::IDX_IRQ_PRI: rdata[7:0] = irq_pri_ff;
            tcc_pkg::IDX_PORT: rdata[7:0] = match_output_port_o;
            default: rdata = tcc_pkg::RST_BUS;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DIV8: assert property ((ctl_ff[3:0] == 4'hD) && (pre_ff != 3'h7) && !ext_clr
        |=> $stable(cnt_ff)) else $error("Counter moved off the divide-by-8 phase");
    AST_HALT: assert property ((ctl_ff[1:0] == tcc_pkg::SRC_HALT) && !ext_clr
        |=> $stable(cnt_ff)) else $error("Halted counter changed");
    AST_CLR_OFF: assert property (!ctl_ff[tcc_pkg::CTL_EXT_CLR] && !tick
        |=> $stable(cnt_ff)) else $error("Counter changed without a tick");
    AST_EXT_CLR: assert property (ext_clr |=> (cnt_ff == 16'h0000) && upd_ff)
        else $error("External clear did not zero counter");
    AST_LOW_FLAG: assert property (ovf_low |=> ctl_ff[tcc_pkg::CTL_LOW_FLAG])
        else $error("Low byte overflow flag not set");
    AST_OVF_FLAG: assert property (ovf_full
        |=> flags_ff[tcc_pkg::FLG_OVF] && (cnt_ff == 16'h0000))
        else $error("Full overflow flag not set");
    AST_CAPTURE: assert property (cap_ev[2]
        |=> (cap_ff[2] == $past(cnt_ff)) && flags_ff[tcc_pkg::FLG_CAP0 + 2])
        else $error("Capture did not latch the counter");
    AST_SET: assert property (match[0] && !match[1] && set_en_ff[3]
        |=> match_output_port_o[3]) else $error("Compare 0 did not set port bit");
    AST_CONFLICT: assert property (match[0] && match[1] && clrtg_ff[0]
        |=> !match_output_port_o[0]) else $error("Simultaneous match did not clear port bit");
    AST_TOGGLE: assert property (match[2] && clrtg_ff[7]
        |=> match_output_port_o[7] == tg_ff[1] && tg_ff[1] != $past(tg_ff[1]))
        else $error("Compare 2 did not toggle port bit");
    AST_TG_RO: assert property (!match[2] |=> $stable(tg_ff))
        else $error("Toggle state changed without a match");
    AST_STICKY: assert property (!(wr_lo && hit(idx, tcc_pkg::IDX_FLAGS))
        |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
        else $error("Event flag cleared by hardware");
    AST_CMP_FLAG: assert property (match[1] |=> flags_ff[tcc_pkg::FLG_MATCH0 + 1])
        else $error("Compare flag not set on match");
    AST_IRQ_GATE: assert property ((irq_en_ff == 8'h00) |=> !irq_o && !irq_prio_o)
        else $error("Interrupt raised while all enables clear");
    AST_PRE_CLR: assert property (ctl_wr && !src_tick && (wb_dat_i[3:0] != ctl_ff[3:0])
        |=> pre_ff == 3'h0) else $error("Prescaler not cleared on selection change");

endmodule

/* verif/tcc_pin_model.sv */
`timescale 1ns/1ps
module tcc_pin_model (
    // Machine clock
    input wire logic clk_i,
    // Pins toward the block
    output logic [3:0] capture_in_o,
    output logic ext_clock_o,
    output logic ext_clear_o
);
    initial begin
        capture_in_o = 4'h0;
        ext_clock_o = 1'b0;
        ext_clear_o = 1'b0;
    end

    // Eight cycles per level so no edge is lost in the synchroniser
    task automatic hold();
        repeat (8) @(posedge clk_i);
    endtask

    task automatic set_cap(input int n, input logic lv);
        capture_in_o[n] <= lv;
        hold();
    endtask

    task automatic pulse_clk();
        ext_clock_o <= 1'b1;
        hold();
        ext_clock_o <= 1'b0;
        hold();
    endtask

    task automatic pulse_clr();
        ext_clear_o <= 1'b1;
        hold();
        ext_clear_o <= 1'b0;
        hold();
    endtask
endmodule

/* verif/test_timer2_capture_compare.sv */
`timescale 1ns/1ps
module test_timer2_capture_compare;
    logic clk_i;
    logic rst_i;
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [31:0] dat;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] cap;
    logic pin_clk;
    logic pin_clr;
    logic [7:0] port;
    logic irq_o;
    logic irq_prio_o;
    logic [15:0] q;
    logic [15:0] a;
    logic [15:0] v;
    logic [5:0] se;
    logic [5:0] ce;
    logic [31:0] seed;
    logic e;
    int errors;
    int checked;
    int k;
    int n;
    int c;
    int lv;
    logic [7:0] regs [5] = '{tcc_pkg::IDX_FLAGS, tcc_pkg::IDX_CTRL, tcc_pkg::IDX_EDGE,
        tcc_pkg::IDX_SET, tcc_pkg::IDX_CLRTG};

    always #2.5 clk_i = ~clk_i;

    tcc_timer2_capcmp tcc_timer2_capcmp_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_in_i(cap), .ext_clock_i(pin_clk),
        .ext_clear_input_i(pin_clr), .match_output_port_o(port), .irq_o(irq_o),
        .irq_prio_o(irq_prio_o));

    tcc_pin_model tcc_pin_model_inst (.clk_i(clk_i), .capture_in_o(cap),
        .ext_clock_o(pin_clk), .ext_clear_o(pin_clr));

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Whole counter ticks seen over d cycles at divide by 1 << k2
    function automatic int ticks(input int d, input int k2);
        return d >> k2;
    endfunction

    task automatic complete_run();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask

    // Prescaler phase leaves one tick of slack either way
    task automatic near(input logic [15:0] g, input int x);
        int d;
        d = int'(g) - x;
        checked++;
        if ($isunknown(g) || d > 1 || d < -1) begin
            errors++;
            $display("BAD %0t ticks %h exp %0d", $time, g, x);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] ad, input logic [15:0] d,
        output logic [15:0] r);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ad, 2'h0};
        dat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("BAD %0t no ack", $time);
            complete_run();
        end else begin
            r = wb_dat_o[15:0];
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        logic [15:0] r;
        xfer(1'b1, ad, d, r);
    endtask

    task automatic rd(input logic [7:0] ad, output logic [15:0] r);
        xfer(1'b0, ad, 16'h0000, r);
    endtask

    task automatic step();
        tcc_pin_model_inst.pulse_clk();
    endtask

    ////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        dat = 32'h00000000;
        seed = 32'h23F933ED;
        errors = 0;
        checked = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i], q);
            chk(q, 16'h0000);
        end
        rd(8'h10, q);
        chk(q, 16'h0000);
        wr(tcc_pkg::IDX_SET, 16'h00FF);
        rd(tcc_pkg::IDX_SET, q);
        chk(q, 16'h003F);
        seed = lfsr(seed);
        wr(tcc_pkg::IDX_EDGE, seed[15:0]);
        rd(tcc_pkg::IDX_EDGE, q);
        chk(q, {8'h00, seed[7:0]});
        for (k = 0; k < 4; k++) begin
            wr(tcc_pkg::IDX_CTRL, 16'(k * 4 + 1));
            rd(tcc_pkg::IDX_COUNT, a);
            repeat (64) @(posedge clk_i);
            rd(tcc_pkg::IDX_COUNT, q);
            near(16'(q - a), ticks(67, k));
        end
        // Test code must behave as halted
        for (k = 0; k < 3; k += 2) begin
            wr(tcc_pkg::IDX_CTRL, 16'(k));
            rd(tcc_pkg::IDX_COUNT, a);
            repeat (20) @(posedge clk_i);
            rd(tcc_pkg::IDX_COUNT, q);
            chk(q, a);
        end
        tcc_pin_model_inst.pulse_clr();
        rd(tcc_pkg::IDX_COUNT, q);
        chk(q, a);
        wr(tcc_pkg::IDX_CTRL, 16'h0020);
        tcc_pin_model_inst.pulse_clr();
        rd(tcc_pkg::IDX_COUNT, q);
        chk(q, 16'h0000);
        wr(tcc_pkg::IDX_CTRL, 16'h0061);
        repeat (300) @(posedge clk_i);
        rd(tcc_pkg::IDX_CTRL, q);
        chk({15'h0, q[4]}, 16'h0001);
        wr(tcc_pkg::IDX_IRQ_EN, 16'h0080);
        repeat (3) @(posedge clk_i);
        chk({15'h0, irq_o}, 16'h0001);
        wr(tcc_pkg::IDX_IRQ_PRI, 16'h0080);
        repeat (3) @(posedge clk_i);
        chk({15'h0, irq_prio_o}, 16'h0001);
        wr(tcc_pkg::IDX_CTRL, 16'h0020);
        repeat (3) @(posedge clk_i);
        chk({15'h0, irq_o}, 16'h0000);
        // Full overflow path: one whole wrap of the counter at divide by 1
        wr(tcc_pkg::IDX_CTRL, 16'h0081);
        repeat (65536) @(posedge clk_i);
        rd(tcc_pkg::IDX_FLAGS, q);
        chk({15'h0, q[7]}, 16'h0001);
        chk({15'h0, irq_o}, 16'h0001);
        wr(tcc_pkg::IDX_IRQ_EN, 16'h0000);
        ////////////////////////////////////////
        wr(tcc_pkg::IDX_CTRL, 16'h0023);
        tcc_pin_model_inst.pulse_clr();
        wr(tcc_pkg::IDX_FLAGS, 16'h0000);
        wr(tcc_pkg::IDX_PORT, 16'h0000);
        seed = lfsr(seed);
        se = seed[5:0];
        ce = seed[13:8];
        wr(tcc_pkg::IDX_CMP0, 16'h0001);
        wr(tcc_pkg::IDX_SET, {10'h0, se});
        wr(tcc_pkg::IDX_CLRTG, 16'h0000);
        step();
        rd(tcc_pkg::IDX_PORT, q);
        chk(q, {10'h0, se});
        wr(tcc_pkg::IDX_CMP1, 16'h0002);
        wr(tcc_pkg::IDX_CLRTG, {8'h00, 2'h3, ce});
        step();
        rd(tcc_pkg::IDX_PORT, q);
        chk(q, {10'h0, se & ~ce});
        wr(tcc_pkg::IDX_CMP2, 16'h0003);
        step();
        rd(tcc_pkg::IDX_PORT, q);
        chk(q, {8'h00, 2'h3, se & ~ce});
        rd(tcc_pkg::IDX_SET, q);
        chk(q, {8'h00, 2'h3, se});
        rd(tcc_pkg::IDX_FLAGS, q);
        chk(q, 16'h0070);
        // Start with bits high so only a clear can pass the check
        wr(tcc_pkg::IDX_PORT, 16'h003F);
        wr(tcc_pkg::IDX_SET, 16'h003F);
        wr(tcc_pkg::IDX_CLRTG, 16'h003F);
        wr(tcc_pkg::IDX_CMP0, 16'h0004);
        wr(tcc_pkg::IDX_CMP1, 16'h0004);
        step();
        rd(tcc_pkg::IDX_PORT, q);
        chk(q, 16'h0000);
        ////////////////////////////////////////
        for (n = 0; n < 4; n++) begin
            for (c = 0; c < 4; c++) begin
                wr(tcc_pkg::IDX_EDGE, 16'(c << (2 * n)));
                for (lv = 1; lv >= 0; lv--) begin
                    wr(tcc_pkg::IDX_FLAGS, 16'h0000);
                    step();
                    rd(tcc_pkg::IDX_COUNT, v);
                    tcc_pin_model_inst.set_cap(n, 1'(lv));
                    rd(tcc_pkg::IDX_FLAGS, q);
                    e = (lv == 1) ? c[0] : c[1];
                    chk({15'h0, q[n]}, {15'h0, e});
                    if (e) begin
                        rd(8'(tcc_pkg::IDX_CAP0 + n), q);
                        chk(q, v);
                    end
                end
            end
        end
        complete_run();
    end
endmodule
